//--- design/addr_map_pkg.sv
// Functional notes
// RULE1: Decode four regions: common, socket, tx, rx.
// RULE2: Receive buffer split register at 0x001a.
// RULE3: Transmit buffer split register at 0x001b.
// RULE4: PPP auth kind at 0x001c-0x001d, high first.
// RULE5: LCP request interval byte at 0x0028.
// RULE6: LCP magic value byte at 0x0029.
// RULE7: Board holds factory test select at 0000.
// RULE8: Logic timed from the reference clock.
// RULE9: Reset low 2us restores all register defaults; here I_RESET is active high and asynchronous, with no minimum width enforced.
// RULE10: 15-bit host address; write latched at strobe rise.
// RULE11: Reserved addresses read zero, ignore writes.
// RULE12: Multi-byte registers byte-wide, MSB at lowest address.
package addr_map_pkg;
  localparam int ADDR_W = 15;

  // ----------------------------------------------------------------
  // Region bases
  // ----------------------------------------------------------------
  localparam logic [14:0] COMMON_BASE  = 15'h0000;
  localparam logic [14:0] COMMON_END   = 15'h0030;
  localparam logic [14:0] SOCKET_BASE  = 15'h0400;
  localparam logic [14:0] SOCKET_END   = 15'h0800;
  localparam logic [14:0] TXMEM_BASE   = 15'h4000;
  localparam logic [14:0] RXMEM_BASE   = 15'h6000;

  // ----------------------------------------------------------------
  // Common register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_GLOBAL_MODE      = 6'h00;
  localparam logic [5:0] OFF_GATEWAY_IP       = 6'h01;
  localparam logic [5:0] OFF_SUBNET_MASK      = 6'h05;
  localparam logic [5:0] OFF_LOCAL_HW_ADDR    = 6'h09;
  localparam logic [5:0] OFF_LOCAL_IP         = 6'h0f;
  localparam logic [5:0] OFF_RSVD_GAP_LO      = 6'h13;
  localparam logic [5:0] OFF_RSVD_GAP_HI      = 6'h14;
  localparam logic [5:0] OFF_INT_FLAGS        = 6'h15;
  localparam logic [5:0] OFF_INT_MASK         = 6'h16;
  localparam logic [5:0] OFF_RETX_TIMEOUT     = 6'h17;
  localparam logic [5:0] OFF_RETX_LIMIT       = 6'h19;
  localparam logic [5:0] OFF_RX_BUF_SPLIT     = 6'h1a;
  localparam logic [5:0] OFF_TX_BUF_SPLIT     = 6'h1b;
  localparam logic [5:0] OFF_PPP_AUTH_KIND    = 6'h1c;
  localparam logic [5:0] OFF_LCP_REQ_INTERVAL = 6'h28;
  localparam logic [5:0] OFF_LCP_MAGIC        = 6'h29;
  localparam logic [5:0] OFF_UNREACH_IP       = 6'h2a;
  localparam logic [5:0] OFF_UNREACH_PORT     = 6'h2e;
  localparam int         COMMON_BYTES         = 48;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_RETX_TIMEOUT = 16'h07d0;
  localparam logic [7:0]  RST_RETX_LIMIT   = 8'h08;
  localparam logic [7:0]  RST_BUF_SPLIT    = 8'h55;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int RESET_MIN_NS   = 2000;
  localparam int RESET_MIN_CYC  = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    REG_COMMON = 2'b00,
    REG_SOCKET = 2'b01,
    REG_TXMEM  = 2'b11,
    REG_RXMEM  = 2'b10
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WLOW  = 2'b01,
    ST_RLOW  = 2'b10
  } bus_state_t;
endpackage

//--- design/host_access_if.sv
interface host_access_if;
  import addr_map_pkg::*;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic        wr_pulse;
  logic        sel;
  region_t     region;
  logic [13:0] region_off;
  logic        mapped;
  modport ctrl (output addr, output wdata, output wr_pulse, output sel,
                input region, input region_off, input mapped);
  modport dec  (input addr, input sel, output region, output region_off, output mapped);
endinterface

//--- design/host_address_map_decoder.sv
module host_address_map_decoder
  import addr_map_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESET,
  input  wire logic [14:0] I_HOST_BYTE_ADDRESS,
  input  wire logic [7:0]  I_DATA,
  input  wire logic        I_CS_N,
  input  wire logic        I_WR_N,
  input  wire logic        I_RD_N,
  input  wire logic [7:0]  I_INT_EVENTS,
  input  wire logic        I_UNREACH_CAPTURE,
  input  wire logic [31:0] I_UNREACH_IP,
  input  wire logic [15:0] I_UNREACH_PORT,
  input  wire logic [7:0]  I_EXT_RDATA,
  output logic [7:0]       O_DATA,
  output logic             O_DATA_OE,
  output logic             O_SOCKET_SEL,
  output logic             O_TXMEM_SEL,
  output logic             O_RXMEM_SEL,
  output logic [13:0]      O_REGION_OFFSET,
  output logic             O_EXT_WR,
  output logic [7:0]       O_EXT_WDATA,
  output logic [7:0]       O_GLOBAL_MODE,
  output logic [7:0]       O_RX_BUFFER_SPLIT,
  output logic [7:0]       O_TX_BUFFER_SPLIT,
  output logic             O_INT_N
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [14:0] addr_s1_r, addr_s2_r;
  logic [7:0]  data_s1_r, data_s2_r;
  logic [2:0]  ctl_s1_r, ctl_s2_r;
  logic        cs_n, wr_n, rd_n;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      addr_s1_r <= 15'h0000;
      addr_s2_r <= 15'h0000;
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
      ctl_s1_r  <= 3'h7;
      ctl_s2_r  <= 3'h7;
    end else begin
      addr_s1_r <= I_HOST_BYTE_ADDRESS;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= I_DATA;
      data_s2_r <= data_s1_r;
      ctl_s1_r  <= {I_CS_N, I_WR_N, I_RD_N};
      ctl_s2_r  <= ctl_s1_r;
    end
  end

  assign cs_n = ctl_s2_r[2];
  assign wr_n = ctl_s2_r[1];
  assign rd_n = ctl_s2_r[0];

  // ----------------------------------------------------------------
  // Strobe tracking
  // ----------------------------------------------------------------
  bus_state_t  st_r, st_nxt;
  logic [14:0] waddr_r, waddr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wr_pulse;

  // Address and data are resampled every cycle while the strobe is low; the write
  // lands when the strobe rises, so late data setup still works.
  always_comb begin
    st_nxt    = st_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wr_pulse  = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (!cs_n && !wr_n) begin
          st_nxt = ST_WLOW;
        end else if (!cs_n && !rd_n) begin
          st_nxt = ST_RLOW;
        end
      end
      ST_WLOW: begin
        waddr_nxt = addr_s2_r;
        wdata_nxt = data_s2_r;
        if (wr_n || cs_n) begin
          st_nxt   = ST_IDLE;
          wr_pulse = 1'b1; // RULE10
        end
      end
      ST_RLOW: begin
        if (rd_n || cs_n) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      st_r    <= ST_IDLE;
      waddr_r <= 15'h0000;
      wdata_r <= 8'h00;
    end else begin
      st_r    <= st_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  host_access_if hbus ();
  assign hbus.addr     = wr_pulse ? waddr_r : addr_s2_r;
  assign hbus.wdata    = wdata_r;
  assign hbus.wr_pulse = wr_pulse;
  // The host may lift chip select with the strobe; keep the region
  // select up through the write pulse so the far side sees it
  assign hbus.sel      = !cs_n || wr_pulse;

  region_decoder u_dec (
    .bus (hbus)
  );

  logic [5:0] coff;
  assign coff = hbus.region_off[5:0];

  // ----------------------------------------------------------------
  // Common register bank
  // ----------------------------------------------------------------
  logic [7:0] regs_r   [COMMON_BYTES];
  logic [7:0] regs_nxt [COMMON_BYTES];
  logic       cwr;
  logic [47:0] unreach_all;

  assign cwr = wr_pulse && hbus.mapped && hbus.region == REG_COMMON;

  // Captured address and port fill the top six bytes, MSB first
  assign unreach_all = {I_UNREACH_IP, I_UNREACH_PORT};

  function automatic logic [7:0] rst_val(input int i);
    logic [7:0] v;
    v = RST_BYTE;
    if (i == int'(OFF_RETX_TIMEOUT)) v = RST_RETX_TIMEOUT[15:8];
    if (i == int'(OFF_RETX_TIMEOUT) + 1) v = RST_RETX_TIMEOUT[7:0];
    if (i == int'(OFF_RETX_LIMIT)) v = RST_RETX_LIMIT;
    if (i == int'(OFF_RX_BUF_SPLIT)) v = RST_BUF_SPLIT;
    if (i == int'(OFF_TX_BUF_SPLIT)) v = RST_BUF_SPLIT;
    return v;
  endfunction

  // Reserved and read-only bytes never take host writes
  function automatic logic writable(input int i);
    return (i <= int'(OFF_PPP_AUTH_KIND) + 1 && i != int'(OFF_RSVD_GAP_LO)
            && i != int'(OFF_RSVD_GAP_HI))
        || i == int'(OFF_LCP_REQ_INTERVAL) || i == int'(OFF_LCP_MAGIC);
  endfunction

  genvar g;
  generate
    for (g = 0; g < COMMON_BYTES; g++) begin : g_byte
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (g == int'(OFF_INT_FLAGS)) begin
          // Writing one clears a flag; a new event wins over the clear
          if (cwr && coff == OFF_INT_FLAGS) begin
            regs_nxt[g] = regs_r[g] & ~hbus.wdata;
          end
          regs_nxt[g] = regs_nxt[g] | I_INT_EVENTS;
        end else if (g >= int'(OFF_UNREACH_IP)) begin
          if (I_UNREACH_CAPTURE) begin
            // A shift keeps every byte lane in range at elaboration
            regs_nxt[g] = 8'(unreach_all >> (8 * (COMMON_BYTES - 1 - g))); // RULE12
          end
        end else if (cwr && coff == 6'(g) && writable(g)) begin // RULE11
          regs_nxt[g] = hbus.wdata; // RULE2 RULE3 RULE4 RULE5 RULE6
        end
      end

      always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
          regs_r[g] <= rst_val(g); // RULE9
        end else begin
          regs_r[g] <= regs_nxt[g]; // RULE8
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  logic [7:0]  rdata;
  logic        oe_nxt;

  always_comb begin
    rdata = 8'h00; // RULE11
    if (hbus.mapped && hbus.region == REG_COMMON) begin
      if (coff != OFF_RSVD_GAP_LO && coff != OFF_RSVD_GAP_HI &&
          !(coff > OFF_PPP_AUTH_KIND + 6'h01 && coff < OFF_LCP_REQ_INTERVAL)) begin
        rdata = regs_r[coff];
      end
    end else if (hbus.mapped) begin
      rdata = I_EXT_RDATA;
    end
    oe_nxt = (st_r == ST_RLOW) && !cs_n && !rd_n;
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DATA            <= 8'h00;
      O_DATA_OE         <= 1'b0;
      O_SOCKET_SEL      <= 1'b0;
      O_TXMEM_SEL       <= 1'b0;
      O_RXMEM_SEL       <= 1'b0;
      O_REGION_OFFSET   <= 14'h0000;
      O_EXT_WR          <= 1'b0;
      O_EXT_WDATA       <= 8'h00;
      O_GLOBAL_MODE     <= RST_BYTE;
      O_RX_BUFFER_SPLIT <= RST_BUF_SPLIT;
      O_TX_BUFFER_SPLIT <= RST_BUF_SPLIT;
      O_INT_N           <= 1'b1;
    end else begin
      O_DATA            <= rdata;
      O_DATA_OE         <= oe_nxt;
      O_SOCKET_SEL      <= hbus.sel && hbus.mapped && hbus.region == REG_SOCKET;
      O_TXMEM_SEL       <= hbus.sel && hbus.mapped && hbus.region == REG_TXMEM;
      O_RXMEM_SEL       <= hbus.sel && hbus.mapped && hbus.region == REG_RXMEM;
      O_REGION_OFFSET   <= hbus.region_off;
      O_EXT_WR          <= wr_pulse && hbus.mapped && hbus.region != REG_COMMON;
      O_EXT_WDATA       <= wdata_r;
      O_GLOBAL_MODE     <= regs_r[OFF_GLOBAL_MODE];
      O_RX_BUFFER_SPLIT <= regs_r[OFF_RX_BUF_SPLIT]; // RULE2
      O_TX_BUFFER_SPLIT <= regs_r[OFF_TX_BUF_SPLIT]; // RULE3
      O_INT_N           <= ~|(regs_r[OFF_INT_FLAGS] & regs_r[OFF_INT_MASK]);
    end
  end
endmodule

//--- design/region_decoder.sv
module region_decoder
  import addr_map_pkg::*;
(
  host_access_if.dec bus
);
  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  always_comb begin
    bus.region     = REG_COMMON;
    bus.region_off = 14'h0000;
    bus.mapped     = 1'b0;
    if (bus.addr >= RXMEM_BASE) begin // RULE1
      bus.region     = REG_RXMEM;
      bus.region_off = 14'(bus.addr - RXMEM_BASE);
      bus.mapped     = 1'b1;
    end else if (bus.addr >= TXMEM_BASE) begin // RULE1
      bus.region     = REG_TXMEM;
      bus.region_off = 14'(bus.addr - TXMEM_BASE);
      bus.mapped     = 1'b1;
    end else if (bus.addr >= SOCKET_BASE && bus.addr < SOCKET_END) begin // RULE1
      bus.region     = REG_SOCKET;
      bus.region_off = 14'(bus.addr - SOCKET_BASE);
      bus.mapped     = 1'b1;
    end else if (bus.addr < COMMON_END) begin // RULE1
      bus.region     = REG_COMMON;
      bus.region_off = 14'(bus.addr);
      bus.mapped     = 1'b1;
    end
  end
endmodule

//--- dv/addr_map_chk.sv
module addr_map_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RESET,
  input wire logic [14:0] I_HOST_BYTE_ADDRESS,
  input wire logic        I_CS_N,
  input wire logic        I_WR_N,
  input wire logic        I_RD_N,
  input wire logic        O_DATA_OE,
  input wire logic        O_SOCKET_SEL,
  input wire logic        O_TXMEM_SEL,
  input wire logic        O_RXMEM_SEL,
  input wire logic        O_EXT_WR,
  input wire logic [7:0]  O_RX_BUFFER_SPLIT,
  input wire logic [7:0]  O_TX_BUFFER_SPLIT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // ------------------------------------------------------------
  // Windows exceed the two-flop sync lag so they never race it
  // ------------------------------------------------------------
  chk_sel_onehot: assert property (
    $onehot0({O_SOCKET_SEL, O_TXMEM_SEL, O_RXMEM_SEL}))
    else $error("two regions selected at once");
  chk_rx_region: assert property (
    (!I_CS_N && I_HOST_BYTE_ADDRESS[14:13] == 2'b11) [*6] |-> O_RXMEM_SEL)
    else $error("receive region not selected");
  chk_tx_region: assert property (
    (!I_CS_N && I_HOST_BYTE_ADDRESS[14:13] == 2'b10) [*6] |-> O_TXMEM_SEL)
    else $error("transmit region not selected");
  chk_sel_idle: assert property (
    I_CS_N [*5] |=> !(O_SOCKET_SEL || O_TXMEM_SEL || O_RXMEM_SEL))
    else $error("region select without chip select");
  chk_oe_idle: assert property (
    I_RD_N [*5] |=> !O_DATA_OE)
    else $error("data driven without read strobe");
  chk_extwr_pulse: assert property (
    O_EXT_WR |=> !O_EXT_WR)
    else $error("external write longer than one cycle");
  chk_extwr_idle: assert property (
    I_CS_N [*6] |=> !O_EXT_WR)
    else $error("external write without chip select");
  chk_split_stable: assert property (
    I_WR_N [*6] |=> $stable({O_RX_BUFFER_SPLIT, O_TX_BUFFER_SPLIT}))
    else $error("buffer split changed without a write");
endmodule

bind host_address_map_decoder addr_map_chk addr_map_chk_i (.I_CLOCK, .I_RESET,
  .I_HOST_BYTE_ADDRESS, .I_CS_N, .I_WR_N, .I_RD_N, .O_DATA_OE, .O_SOCKET_SEL,
  .O_TXMEM_SEL, .O_RXMEM_SEL, .O_EXT_WR, .O_RX_BUFFER_SPLIT, .O_TX_BUFFER_SPLIT);

//--- dv/host_model.sv
module host_model (
  input  wire logic        i_clock,
  input  wire logic [7:0]  i_data,
  output logic [14:0]      o_addr,
  output logic [7:0]       o_data,
  output logic             o_cs_n,
  output logic             o_wr_n,
  output logic             o_rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board keeps factory test select at its normal code
  initial begin
    o_addr = 15'h0000;
    o_data = 8'h00;
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
  end
  // ------------------------------------------------------------
  // Write strobe low and high 4 cycles each, read strobe low 6 and high 4, above the 3-cycle floor
  // ------------------------------------------------------------
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_data <= d;
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    o_wr_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_addr <= 15'h0000;
    o_data <= ~d;
  endtask
  // Address pins fall to the pull-down level once released
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_data <= ~o_data;
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    d = i_data;
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_addr <= 15'h0000;
  endtask
endmodule

//--- dv/tb_top.sv
module tb_top
  import addr_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock;
  logic        i_reset;
  logic [7:0]  int_events;
  logic        unreach_cap;
  logic [47:0] ur;
  logic [14:0] addr;
  logic [7:0]  hdata;
  logic [7:0]  rdata;
  logic [7:0]  data_bus;
  logic        data_oe;
  logic        cs_n;
  logic        wr_n;
  logic        rd_n;
  logic [13:0] region_off;
  logic        ext_wr;
  logic [7:0]  ext_wdata;
  logic [7:0]  last_wdata;
  logic [7:0]  rx_split;
  logic [7:0]  tx_split;
  logic [7:0]  gmode;
  logic        int_n;
  logic        sock_sel;
  logic        tx_sel;
  logic        rx_sel;
  logic [13:0] last_off;
  logic [2:0]  last_sel;
  logic [7:0]  got;
  int          n_mismatch;
  int          comparisons;
  int          cycles;
  logic [14:0] dflt_a[7] = '{15'h0, 15'h17, 15'h18, 15'h19, 15'h1a, 15'h1b, 15'h1d};
  logic [7:0]  dflt_v[7] = '{RST_BYTE, RST_RETX_TIMEOUT[15:8], RST_RETX_TIMEOUT[7:0],
                             RST_RETX_LIMIT, RST_BUF_SPLIT, RST_BUF_SPLIT, RST_BYTE};
  logic [14:0] rw_a[8] = '{15'h1a, 15'h1b, 15'h1c, 15'h1d, 15'h28, 15'h29, 15'h01, 15'h0e};
  logic [14:0] rsv_a[7] = '{15'h13, 15'h14, 15'h1e, 15'h27, 15'h2a, 15'h30, 15'h3ff};
  logic [14:0] ext_a[6] = '{15'h400, 15'h7ff, 15'h4000, 15'h5fff, 15'h6000, 15'h7fff};

  // Shared wire: the design wins while it drives
  assign data_bus = data_oe ? rdata : hdata;

  host_address_map_decoder host_address_map_decoder_i (.I_CLOCK(i_clock), .I_RESET(i_reset),
    .I_HOST_BYTE_ADDRESS(addr), .I_DATA(data_bus), .I_CS_N(cs_n), .I_WR_N(wr_n),
    .I_RD_N(rd_n), .I_INT_EVENTS(int_events), .I_UNREACH_CAPTURE(unreach_cap),
    .I_UNREACH_IP(ur[47:16]), .I_UNREACH_PORT(ur[15:0]),
    .I_EXT_RDATA(region_off[7:0] ^ 8'ha5), .O_DATA(rdata), .O_DATA_OE(data_oe),
    .O_SOCKET_SEL(sock_sel), .O_TXMEM_SEL(tx_sel), .O_RXMEM_SEL(rx_sel),
    .O_REGION_OFFSET(region_off), .O_EXT_WR(ext_wr), .O_EXT_WDATA(ext_wdata),
    .O_GLOBAL_MODE(gmode), .O_RX_BUFFER_SPLIT(rx_split), .O_TX_BUFFER_SPLIT(tx_split),
    .O_INT_N(int_n));

  host_model host_model_i (.i_clock(i_clock), .i_data(data_bus), .o_addr(addr),
    .o_data(hdata), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (ext_wr === 1'b1) begin
      last_wdata <= ext_wdata;
      last_off   <= region_off;
      last_sel   <= {sock_sel, tx_sel, rx_sel};
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    host_model_i.rd(a, got);
    check(got, e);
  endtask

  task automatic do_reset;
    i_reset <= 1'b1;
    repeat (20) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask

  initial begin
    i_reset = 1'b1;
    int_events = 8'h00;
    unreach_cap = 1'b0;
    ur = 48'h0;
    cycles = 0;
    do_reset();
    foreach (dflt_a[k]) rdchk(dflt_a[k], dflt_v[k]);
    foreach (rw_a[k]) host_model_i.wr(rw_a[k], rw_a[k][7:0] ^ 8'h3c);
    foreach (rw_a[k]) rdchk(rw_a[k], rw_a[k][7:0] ^ 8'h3c);
    check(rx_split, 8'h1a ^ 8'h3c);
    check(tx_split, 8'h1b ^ 8'h3c);
    foreach (rsv_a[k]) host_model_i.wr(rsv_a[k], 8'hff);
    foreach (rsv_a[k]) rdchk(rsv_a[k], 8'h00);
    host_model_i.wr(15'h00, 8'h81);
    host_model_i.wr(15'h16, 8'h05);
    int_events <= 8'h04;
    @(posedge i_clock);
    int_events <= 8'h00;
    repeat (3) @(posedge i_clock);
    check(gmode, 8'h81);
    check({7'h00, int_n}, 8'h00);
    rdchk(15'h15, 8'h04);
    host_model_i.wr(15'h15, 8'h04);
    @(posedge i_clock);
    check({7'h00, int_n}, 8'h01);
    rdchk(15'h15, 8'h00);
    ur <= 48'h0a0b0c0d1234;
    @(posedge i_clock);
    unreach_cap <= 1'b1;
    @(posedge i_clock);
    unreach_cap <= 1'b0;
    for (int k = 0; k < 6; k++) rdchk(15'h2a + 15'(k), ur[47 - 8 * k -: 8]);
    foreach (ext_a[k]) rdchk(ext_a[k], ext_a[k][7:0] ^ 8'ha5);
    host_model_i.wr(15'h4003, 8'h77);
    // Captured values land on the edge the task returns on
    @(posedge i_clock);
    check(last_wdata, 8'h77);
    check(last_off[7:0], 8'h03);
    check({5'h00, last_sel}, 8'h02);
    host_model_i.wr(15'h1a, 8'h12);
    do_reset();
    rdchk(15'h1a, RST_BUF_SPLIT);
    check(rx_split, RST_BUF_SPLIT);
    check(gmode, RST_BYTE);
    check({7'h00, int_n}, 8'h01);
    summarize();
  end
endmodule
